// File: hdl/rbcr_pkg.sv
// Register map, field layout and serial-port helpers for the rail behaviour configuration bank
package rbcr_pkg;

  localparam logic [7:0] ADDR_LOWGATE_RIPPLE = 8'h05;
  localparam logic [7:0] ADDR_TRANSITION_UV  = 8'h06;
  localparam logic [7:0] ADDR_TEMP_POLARITY  = 8'h07;

  localparam logic [7:0] RST_LOWGATE_RIPPLE  = 8'h80;
  localparam logic [7:0] RST_TRANSITION_UV   = 8'h21;
  localparam logic [7:0] RST_TEMP_POLARITY   = 8'h10;

  // Writable bits; reserved bits of 0x05 are read-only at their default
  localparam logic [7:0] WMASK_LOWGATE_RIPPLE = 8'h87;
  localparam logic [7:0] WMASK_TRANSITION_UV  = 8'hff;
  localparam logic [7:0] WMASK_TEMP_POLARITY  = 8'hff;

  localparam int LOWGATE_BIT          = 7;
  localparam int RIPPLE_LSB           = 0;
  localparam int RIPPLE_W             = 3;
  localparam int EXIT_PULSE_RAIL1_BIT = 6;
  localparam int UV_MASK_RAIL1_BIT    = 3;
  localparam int TEMP_POL_RAIL1_BIT   = 7;
  localparam int NUM_RAILS            = 3;

  localparam int WIN_LOW_MV  = 300;
  localparam int WIN_HIGH_MV = 900;
  localparam int UV_PER_MV   = 1000;

  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef struct packed {
    logic [7:0] lowgate_ripple_config_c;
    logic [7:0] transition_uv_config;
    logic [7:0] temp_sense_polarity;
  } rbcr_regs_t;

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ACK_ADDR, S_REG, S_ACK_REG, S_WDATA, S_ACK_W, S_RDATA, S_RACK
  } rbcr_state_t;

  localparam rbcr_regs_t REGS_RESET = '{RST_LOWGATE_RIPPLE, RST_TRANSITION_UV, RST_TEMP_POLARITY};

  // Unmapped offsets read as zero
  function automatic logic [7:0] rbcr_read(input rbcr_regs_t r, input logic [7:0] ptr);
    case (ptr)
      ADDR_LOWGATE_RIPPLE: rbcr_read = r.lowgate_ripple_config_c;
      ADDR_TRANSITION_UV:  rbcr_read = r.transition_uv_config;
      ADDR_TEMP_POLARITY:  rbcr_read = r.temp_sense_polarity;
      default:             rbcr_read = 8'h00;
    endcase
  endfunction : rbcr_read

  // Unmapped offsets swallow the write
  function automatic rbcr_regs_t rbcr_write(input rbcr_regs_t r, input logic [7:0] ptr, input logic [7:0] d);
    rbcr_write = r;
    case (ptr)
      ADDR_LOWGATE_RIPPLE: rbcr_write.lowgate_ripple_config_c =
        (r.lowgate_ripple_config_c & ~WMASK_LOWGATE_RIPPLE) | (d & WMASK_LOWGATE_RIPPLE);
      ADDR_TRANSITION_UV:  rbcr_write.transition_uv_config =
        (r.transition_uv_config & ~WMASK_TRANSITION_UV) | (d & WMASK_TRANSITION_UV);
      ADDR_TEMP_POLARITY:  rbcr_write.temp_sense_polarity =
        (r.temp_sense_polarity & ~WMASK_TEMP_POLARITY) | (d & WMASK_TEMP_POLARITY);
      default:             rbcr_write = r;
    endcase
  endfunction : rbcr_write

endpackage : rbcr_pkg

// File: hdl/rbcr_top.sv
// Rail behaviour configuration bank with its two-wire serial register port
`timescale 1ns/1ns
module rbcr_top
  import rbcr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR        = 7'h20,
  parameter int         VCODE_W         = 8,
  parameter int         VCODE_STEP_UV   = 5000,
  parameter int         VCODE_OFFSET_UV = 0
)(
  input  wire logic               mclk_in,
  input  wire logic               rst_n_in,
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe_out,
  input  wire logic [VCODE_W-1:0] voltage_code_rail3_in,
  input  wire logic               decay_target_reached_rail3_in,
  input  wire logic [2:0]         light_load_state_in,
  input  wire logic [2:0]         fastmode_active_in,
  input  wire logic [2:0]         undervolt_detect_in,
  output logic                    decay_end_lowgate_on_rail3_out,
  output logic [RIPPLE_W-1:0]     ripple_comp_gain_rail3_out,
  output logic [2:0]              lowpower_exit_pulse_out,
  output logic [2:0]              undervolt_trip_out,
  output logic [2:0]              temp_table_polarity_out
);

  typedef struct packed {
    rbcr_state_t          state;
    logic [3:0]           cnt;
    logic [7:0]           sh;
    logic [7:0]           tx;
    logic [7:0]           ptr;
    logic                 nack;
    logic                 sda_oe;
    logic                 sda_lvl;
    logic                 scl_s1;
    logic                 scl_s2;
    logic                 scl_p;
    logic                 sda_s1;
    logic                 sda_s2;
    logic                 sda_p;
    rbcr_regs_t           regs;
    logic [2:0]           lp_prev;
    logic                 lowgate_on;
    logic [RIPPLE_W-1:0]  ripple_gain;
    logic [2:0]           exit_pulse;
    logic [2:0]           uv_trip;
  } rbcr_st_t;

  localparam rbcr_st_t ST_RESET = '{state: S_IDLE, regs: REGS_RESET, scl_s1: 1'b1, scl_s2: 1'b1, scl_p: 1'b1,
                                    sda_s1: 1'b1, sda_s2: 1'b1, sda_p: 1'b1, default: '0};
  localparam logic [31:0] WIN_LOW_UV  = 32'(WIN_LOW_MV * UV_PER_MV);
  localparam logic [31:0] WIN_HIGH_UV = 32'(WIN_HIGH_MV * UV_PER_MV);

  rbcr_st_t    st_q;
  rbcr_st_t    st_d;
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;
  logic        wr_fire;
  logic [31:0] code_uv;
  logic        in_window;

  assign scl_rise  = st_q.scl_s2 & ~st_q.scl_p;
  assign scl_fall  = ~st_q.scl_s2 & st_q.scl_p;
  assign bus_start = st_q.scl_s2 & st_q.scl_p & st_q.sda_p & ~st_q.sda_s2;
  assign bus_stop  = st_q.scl_s2 & st_q.scl_p & ~st_q.sda_p & st_q.sda_s2;
  assign code_uv   = 32'(voltage_code_rail3_in) * 32'(VCODE_STEP_UV) + 32'(VCODE_OFFSET_UV);
  assign in_window = (code_uv >= WIN_LOW_UV) && (code_uv <= WIN_HIGH_UV);

  always_comb
  begin
    st_d    = st_q;
    wr_fire = 1'b0;
    st_d.scl_s1 = scl_in;
    st_d.scl_s2 = st_q.scl_s1;
    st_d.scl_p  = st_q.scl_s2;
    st_d.sda_s1 = sda_in;
    st_d.sda_s2 = st_q.sda_s1;
    st_d.sda_p  = st_q.sda_s2;
    st_d.sda_lvl = 1'b0;
    if (bus_start)
    begin
      st_d.state  = S_ADDR;
      st_d.cnt    = '0;
      st_d.sda_oe = 1'b0;
    end
    else if (bus_stop)
    begin
      st_d.state  = S_IDLE;
      st_d.sda_oe = 1'b0;
    end
    else if (scl_rise)
    begin
      case (st_q.state)
        S_ADDR, S_REG, S_WDATA:
        begin
          st_d.sh  = {st_q.sh[6:0], st_q.sda_s2};
          st_d.cnt = st_q.cnt + 4'h1;
        end
        S_RDATA: st_d.cnt = st_q.cnt + 4'h1;
        S_RACK:  st_d.nack = st_q.sda_s2;
        default: st_d.cnt = st_q.cnt;
      endcase
    end
    else if (scl_fall)
    begin
      case (st_q.state)
        S_ADDR:
          if (st_q.cnt == BYTE_BITS)
          begin
            st_d.state  = (st_q.sh[7:1] == DEV_ADDR) ? S_ACK_ADDR : S_IDLE;
            st_d.sda_oe = (st_q.sh[7:1] == DEV_ADDR);
          end
        S_ACK_ADDR:
        begin
          st_d.cnt = '0;
          if (st_q.sh[0])
          begin
            st_d.state  = S_RDATA;
            st_d.tx     = rbcr_read(st_q.regs, st_q.ptr);
            st_d.sda_oe = ~st_d.tx[7];
          end
          else
          begin
            st_d.state  = S_REG;
            st_d.sda_oe = 1'b0;
          end
        end
        S_REG:
          if (st_q.cnt == BYTE_BITS)
          begin
            st_d.state  = S_ACK_REG;
            st_d.ptr    = st_q.sh;
            st_d.sda_oe = 1'b1;
          end
        S_ACK_REG, S_ACK_W:
        begin
          st_d.state  = S_WDATA;
          st_d.cnt    = '0;
          st_d.sda_oe = 1'b0;
        end
        S_WDATA:
          if (st_q.cnt == BYTE_BITS)
          begin
            wr_fire     = 1'b1;
            st_d.regs   = rbcr_write(st_q.regs, st_q.ptr, st_q.sh);
            st_d.ptr    = st_q.ptr + 8'h01;
            st_d.state  = S_ACK_W;
            st_d.sda_oe = 1'b1;
          end
        S_RDATA:
          if (st_q.cnt == BYTE_BITS)
          begin
            st_d.state  = S_RACK;
            st_d.sda_oe = 1'b0;
          end
          else
          begin
            st_d.tx     = {st_q.tx[6:0], 1'b0};
            st_d.sda_oe = ~st_d.tx[7];
          end
        S_RACK:
          if (st_q.nack)
            st_d.state = S_IDLE;
          else
          begin
            st_d.state  = S_RDATA;
            st_d.cnt    = '0;
            st_d.ptr    = st_q.ptr + 8'h01;
            st_d.tx     = rbcr_read(st_q.regs, st_d.ptr);
            st_d.sda_oe = ~st_d.tx[7];
          end
        default: st_d.sda_oe = 1'b0;
      endcase
    end
    st_d.lowgate_on  = st_q.regs.lowgate_ripple_config_c[LOWGATE_BIT] & decay_target_reached_rail3_in;
    st_d.ripple_gain = in_window ? st_q.regs.lowgate_ripple_config_c[RIPPLE_LSB +: RIPPLE_W] : '0;
    st_d.lp_prev     = light_load_state_in;
    for (int i = 0; i < NUM_RAILS; i++)
    begin
      st_d.exit_pulse[i] = st_q.regs.transition_uv_config[EXIT_PULSE_RAIL1_BIT - i] &
                           st_q.lp_prev[i] & ~light_load_state_in[i];
      st_d.uv_trip[i]    = undervolt_detect_in[i] &
                           ~(fastmode_active_in[i] & st_q.regs.transition_uv_config[UV_MASK_RAIL1_BIT - i]);
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      st_q <= ST_RESET;
    else
      st_q <= st_d;
  end

  assign sda_out                        = st_q.sda_lvl;
  assign sda_oe_out                     = st_q.sda_oe;
  assign decay_end_lowgate_on_rail3_out = st_q.lowgate_on;
  assign ripple_comp_gain_rail3_out     = st_q.ripple_gain;
  assign lowpower_exit_pulse_out        = st_q.exit_pulse;
  assign undervolt_trip_out             = st_q.uv_trip;
  assign temp_table_polarity_out        = {st_q.regs.temp_sense_polarity[TEMP_POL_RAIL1_BIT - 2],
                                           st_q.regs.temp_sense_polarity[TEMP_POL_RAIL1_BIT - 1],
                                           st_q.regs.temp_sense_polarity[TEMP_POL_RAIL1_BIT]};

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  property p_lowgate;
    decay_target_reached_rail3_in && st_q.regs.lowgate_ripple_config_c[7] |=> decay_end_lowgate_on_rail3_out;
  endproperty
  a_lowgate: assert property (p_lowgate) else $error("low gate request missing");

  property p_ripple_gain;
    in_window ##1 $stable(st_q.regs) |-> ripple_comp_gain_rail3_out == st_q.regs.lowgate_ripple_config_c[2:0];
  endproperty
  a_ripple_gain: assert property (p_ripple_gain) else $error("ripple gain not applied");

  property p_ripple_window;
    !in_window |=> ripple_comp_gain_rail3_out == 3'h0;
  endproperty
  a_ripple_window: assert property (p_ripple_window) else $error("ripple gain outside window");

  property p_exit_pulse;
    lowpower_exit_pulse_out[0] |-> $past(st_q.regs.transition_uv_config[6]) && !$past(light_load_state_in[0])
                                   && $past(light_load_state_in[0], 2) ##1 !lowpower_exit_pulse_out[0];
  endproperty
  a_exit_pulse: assert property (p_exit_pulse) else $error("exit pulse without cause");

  property p_uv_block;
    undervolt_detect_in[2] && fastmode_active_in[2] && st_q.regs.transition_uv_config[1] |=> !undervolt_trip_out[2];
  endproperty
  a_uv_block: assert property (p_uv_block) else $error("undervoltage not blocked");

  property p_uv_pass;
    undervolt_detect_in[0] && !fastmode_active_in[0] |=> undervolt_trip_out[0];
  endproperty
  a_uv_pass: assert property (p_uv_pass) else $error("undervoltage trip lost");

  property p_temp_stable;
    !wr_fire |=> $stable(temp_table_polarity_out);
  endproperty
  a_temp_stable: assert property (p_temp_stable) else $error("temperature polarity changed without write");

  property p_reserved;
    st_q.regs.lowgate_ripple_config_c[6:3] == 4'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits changed");

  property p_idle_release;
    st_q.state == S_IDLE |-> !sda_oe_out;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("data line driven while idle");

  c_write:  cover property (wr_fire ##1 st_q.state == S_ACK_W);
  c_read:   cover property (st_q.state == S_RACK ##[1:200] st_q.state == S_RDATA);
  c_pulse:  cover property (lowpower_exit_pulse_out[1]);
  c_window: cover property (ripple_comp_gain_rail3_out != 3'h0);

endmodule : rbcr_top

// File: tb/rbcr_top_tb.sv
// Self-checking bench for the rail behaviour configuration bank and its serial port
`timescale 1ns/1ns
module rbcr_top_tb;
  import rbcr_pkg::*;
  localparam logic [6:0] DEV   = 7'h20;
  localparam int         VSTEP = 5000;
  logic       mclk_in  = 1'b0;
  logic       rst_n_in = 1'b0;
  logic       scl      = 1'b1;
  logic       sda_drv  = 1'b1;
  logic       sda_out;
  logic       sda_oe_out;
  logic       lg_out;
  logic [7:0] vcode    = 8'h00;
  logic       reached  = 1'b0;
  logic [2:0] llst     = 3'h0;
  logic [2:0] fast     = 3'h0;
  logic [2:0] uvd      = 3'h0;
  logic [2:0] gain_out;
  logic [2:0] pulse_out;
  logic [2:0] trip_out;
  logic [2:0] pol_out;
  logic [7:0] rd;
  logic [7:0] cnt;
  logic       ack;
  int         uv;
  int         n_mismatch = 0;
  int         n_compared = 0;
  logic [7:0] codes [6]  = '{8'h3b, 8'h3c, 8'hb4, 8'hb5, 8'h00, 8'hff};
  // Open-drain data line with pull-up
  wire        sda_w = sda_drv & (sda_oe_out ? sda_out : 1'b1);

  always #4 mclk_in = ~mclk_in;

  rbcr_top #(.DEV_ADDR(DEV), .VCODE_W(8), .VCODE_STEP_UV(VSTEP), .VCODE_OFFSET_UV(0)) dut (
    .mclk_in                       (mclk_in),
    .rst_n_in                      (rst_n_in),
    .scl_in                        (scl),
    .sda_in                        (sda_w),
    .sda_out                       (sda_out),
    .sda_oe_out                    (sda_oe_out),
    .voltage_code_rail3_in         (vcode),
    .decay_target_reached_rail3_in (reached),
    .light_load_state_in           (llst),
    .fastmode_active_in            (fast),
    .undervolt_detect_in           (uvd),
    .decay_end_lowgate_on_rail3_out(lg_out),
    .ripple_comp_gain_rail3_out    (gain_out),
    .lowpower_exit_pulse_out       (pulse_out),
    .undervolt_trip_out            (trip_out),
    .temp_table_polarity_out       (pol_out)
  );

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : tick

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    if (n_mismatch == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  // One serial bit: data set in the low phase, sampled in the high phase
  task automatic clk_bit(input logic b, output logic s);
    sda_drv = b;
    tick(10);
    scl = 1'b1;
    tick(10);
    s = sda_w;
    scl = 1'b0;
    tick(10);
  endtask : clk_bit

  // Eight bits MSB first, then the acknowledge slot driven with mack
  task automatic byte_io(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      clk_bit(d[i], s);
      q = {q[6:0], s};
    end
    clk_bit(mack, s);
    a = ~s;
  endtask : byte_io

  task automatic start();
    sda_drv = 1'b1;
    tick(10);
    scl = 1'b1;
    tick(10);
    sda_drv = 1'b0;
    tick(10);
    scl = 1'b0;
    tick(10);
  endtask : start

  task automatic stop();
    sda_drv = 1'b0;
    tick(10);
    scl = 1'b1;
    tick(10);
    sda_drv = 1'b1;
    tick(10);
  endtask : stop

  task automatic send(input logic [7:0] d);
    logic [7:0] q;
    byte_io(d, 1'b1, q, ack);
    check({7'h00, ack}, 8'h01);
  endtask : send

  task automatic wr(input logic [7:0] off, input logic [7:0] d0, input logic [7:0] d1, input bit two);
    start();
    send({DEV, 1'b0});
    send(off);
    send(d0);
    if (two)
      send(d1);
    stop();
  endtask : wr

  task automatic rdr(input logic [7:0] off);
    start();
    send({DEV, 1'b0});
    send(off);
    start();
    send({DEV, 1'b1});
    byte_io(8'hff, 1'b1, rd, ack);
    stop();
  endtask : rdr

  // Rail i enters then leaves light load; counts cycles whose exit pulse is not low
  task automatic pulse_cnt(input int i);
    llst[i] = 1'b1;
    tick(3);
    llst[i] = 1'b0;
    cnt = 8'h00;
    repeat (5)
    begin
      tick(1);
      if (pulse_out[i] !== 1'b0)
        cnt++;
    end
  endtask : pulse_cnt

  initial
  begin
    repeat (100000) @(posedge mclk_in);
    n_mismatch++;
    close_out();
  end

  initial
  begin
    tick(10);
    rst_n_in = 1'b1;
    tick(5);
    check({5'h00, pol_out}, 8'h00);
    rdr(ADDR_LOWGATE_RIPPLE);
    check(rd, 8'h80);
    rdr(ADDR_TRANSITION_UV);
    check(rd, 8'h21);
    rdr(ADDR_TEMP_POLARITY);
    check(rd, 8'h10);
    // Write to an unmapped offset is acknowledged and swallowed
    wr(8'h08, 8'h5a, 8'h00, 1'b0);
    rdr(8'h08);
    check(rd, 8'h00);
    // Foreign device address is not acknowledged
    start();
    byte_io({DEV + 7'h01, 1'b0}, 1'b1, rd, ack);
    check({7'h00, ack}, 8'h00);
    stop();
    reached = 1'b1;
    tick(3);
    check({7'h00, lg_out}, 8'h01);
    wr(ADDR_LOWGATE_RIPPLE, 8'hff, 8'h00, 1'b0);
    rdr(ADDR_LOWGATE_RIPPLE);
    check(rd, 8'h87);
    // Window edges of the ripple compensation, gain 7
    foreach (codes[k])
    begin
      vcode = codes[k];
      uv = int'(codes[k]) * VSTEP;
      tick(3);
      check({5'h00, gain_out}, (uv >= WIN_LOW_MV * UV_PER_MV && uv <= WIN_HIGH_MV * UV_PER_MV) ? 8'h07 : 8'h00);
    end
    wr(ADDR_LOWGATE_RIPPLE, 8'h05, 8'h00, 1'b0);
    vcode = 8'h64;
    tick(3);
    check({5'h00, gain_out}, 8'h05);
    check({7'h00, lg_out}, 8'h00);
    // Two bytes in one write: pointer steps to the next offset
    wr(ADDR_TRANSITION_UV, 8'h70, 8'ha0, 1'b1);
    rdr(ADDR_TEMP_POLARITY);
    check(rd, 8'ha0);
    check({5'h00, pol_out}, 8'h05);
    for (int i = 0; i < NUM_RAILS; i++)
    begin
      pulse_cnt(i);
      check(cnt, 8'h01);
    end
    wr(ADDR_TRANSITION_UV, 8'h0e, 8'h00, 1'b0);
    for (int i = 0; i < NUM_RAILS; i++)
    begin
      pulse_cnt(i);
      check(cnt, 8'h00);
    end
    uvd = 3'h7;
    fast = 3'h7;
    tick(3);
    check({5'h00, trip_out}, 8'h00);
    fast = 3'h2;
    tick(3);
    check({5'h00, trip_out}, 8'h05);
    wr(ADDR_TRANSITION_UV, 8'h08, 8'h00, 1'b0);
    fast = 3'h7;
    tick(3);
    check({5'h00, trip_out}, 8'h06);
    // Burst read: master acknowledges the first byte, pointer steps to the next offset
    start();
    send({DEV, 1'b0});
    send(ADDR_TRANSITION_UV);
    start();
    send({DEV, 1'b1});
    byte_io(8'hff, 1'b0, rd, ack);
    check(rd, 8'h08);
    byte_io(8'hff, 1'b1, rd, ack);
    check(rd, 8'ha0);
    stop();
    // Mid-run reset brings every register back to its default
    rst_n_in = 1'b0;
    tick(2);
    rst_n_in = 1'b1;
    tick(3);
    check({5'h00, pol_out}, 8'h00);
    check({5'h00, trip_out}, 8'h07);
    check({7'h00, lg_out}, 8'h01);
    rdr(ADDR_TRANSITION_UV);
    check(rd, 8'h21);
    close_out();
  end
endmodule : rbcr_top_tb
